// *** pkg/dc1_params.svh ***
// Purpose: constants of the one-channel dma block: register indices, field positions, reset values
// Assumes: register byte address is four times the index
// Notes: included by the package, the assertions and the bench
`ifndef DC1_PARAMS_SVH
`define DC1_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define DC1_IDX_CTRL 12'hFB8
`define DC1_IDX_PADDR 12'hFB9
`define DC1_IDX_HIGH 12'hFBA
`define DC1_IDX_START 12'hFBB
`define DC1_IDX_END 12'hFBC
`define DC1_IDX_STAT 12'hFB5
`define DC1_IDX_MASK 12'hFB6

// ----------------------------------------------------------------
// channel_control field positions
// ----------------------------------------------------------------
`define DC1_CTL_SRC_LSB 0
`define DC1_CTL_SRC_MSB 2
`define DC1_CTL_WORD 3
`define DC1_CTL_IRQEN 4
`define DC1_CTL_DIR 5
`define DC1_CTL_LOOP 6
`define DC1_CTL_EN 7

// ----------------------------------------------------------------
// address_high_nibbles field positions
// ----------------------------------------------------------------
`define DC1_HI_START_LSB 0
`define DC1_HI_START_MSB 3
`define DC1_HI_END_LSB 4
`define DC1_HI_END_MSB 7

// ----------------------------------------------------------------
// status / mask bit positions
// ----------------------------------------------------------------
`define DC1_ST_DONE 0
`define DC1_ST_OVR 1

// ----------------------------------------------------------------
// reset values, trigger codes, peripheral page
// ----------------------------------------------------------------
`define DC1_RST_CTRL 8'h00
`define DC1_RST_BYTE 8'h00
`define DC1_RST_STAT 8'h00
`define DC1_RST_MASK 8'h00
`define DC1_SRC_TIMER0 3'h0
`define DC1_SRC_UART0 3'h4
`define DC1_SRC_RSVD 3'h7
`define DC1_PERIPH_PAGE 4'hF

`endif

// *** pkg/dc1_pkg.sv ***
// Purpose: shared types of the one-channel dma block
// Assumes: dc1_params.svh holds the numbers
// Notes: only the transfer state type lives here
package dc1_pkg;
  `include "dc1_params.svh"

  // transfer sequencer states
  typedef enum logic [1:0] {
    DC1_IDLE = 2'b00,
    DC1_READ = 2'b01,
    DC1_WRITE = 2'b10
  } dc1_state_t;
endpackage

// *** design/dc1_channel.sv ***
// Purpose: one dma channel with apb registers moving bytes between register file and a peripheral register
// Assumes: trigger pulses and register-file bus are on pclk; apb3 slave, zero wait states
// Notes: each byte is one read then one write on the register-file bus
`timescale 1ns/100ps

module dc1_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] timer_trig,
  input wire logic [1:0] uart_tx_empty,
  input wire logic twi_tx_empty,
  output logic rf_req,
  output logic rf_we,
  output logic [11:0] rf_addr,
  output logic [7:0] rf_wdata,
  input wire logic [7:0] rf_rdata,
  input wire logic rf_ack,
  output logic irq
);
  import dc1_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] periph_r;
  logic [7:0] high_r;
  logic [7:0] start_r;
  logic [7:0] end_r;
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  logic [11:0] cur_r;
  logic [7:0] data_r;
  logic byte_idx_r;
  logic pend_r;
  logic [31:0] prdata_r;
  dc1_state_t state_r;

  logic wr_acc;
  logic rd_setup;
  logic rd_acc;
  logic [13:0] idx;
  logic aligned;
  logic mapped;
  logic trig;
  logic [11:0] start_addr;
  logic [11:0] end_addr;
  logic [11:0] periph_addr;
  logic at_end;
  logic byte_done;
  logic last_byte;
  logic done_evt;
  logic ovr_evt;
  logic ch_en;
  logic stat_rd;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // index is the word address; the two low byte bits must be zero
  assign idx = paddr[15:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_acc = psel & penable & ~pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;
  // access phase of a status read, the only thing that clears flags
  assign stat_rd = rd_acc & (idx == {2'h0, `DC1_IDX_STAT});

  // address decoding, unmapped words answer with an error
  always_comb begin
    if (!aligned) begin
      mapped = 1'b0;
    end else if (idx == {2'h0, `DC1_IDX_CTRL}) begin
      mapped = 1'b1;
    end else if (idx == {2'h0, `DC1_IDX_PADDR}) begin
      mapped = 1'b1;
    end else if (idx == {2'h0, `DC1_IDX_HIGH}) begin
      mapped = 1'b1;
    end else if (idx == {2'h0, `DC1_IDX_START}) begin
      mapped = 1'b1;
    end else if (idx == {2'h0, `DC1_IDX_END}) begin
      mapped = 1'b1;
    end else if (idx == {2'h0, `DC1_IDX_STAT}) begin
      mapped = 1'b1;
    end else if (idx == {2'h0, `DC1_IDX_MASK}) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // read data is captured in the setup cycle so prdata is a flop through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (!aligned) begin
        prdata_r <= 32'h0000_0000;
      end else if (idx == {2'h0, `DC1_IDX_CTRL}) begin
        prdata_r <= {24'h00_0000, ctrl_r};
      end else if (idx == {2'h0, `DC1_IDX_PADDR}) begin
        prdata_r <= {24'h00_0000, periph_r};
      end else if (idx == {2'h0, `DC1_IDX_HIGH}) begin
        prdata_r <= {24'h00_0000, high_r};
      end else if (idx == {2'h0, `DC1_IDX_START}) begin
        // running channel shows where it is now
        prdata_r <= {24'h00_0000, ch_en ? cur_r[7:0] : start_r};
      end else if (idx == {2'h0, `DC1_IDX_END}) begin
        prdata_r <= {24'h00_0000, end_r};
      end else if (idx == {2'h0, `DC1_IDX_STAT}) begin
        prdata_r <= {24'h00_0000, stat_r};
      end else if (idx == {2'h0, `DC1_IDX_MASK}) begin
        prdata_r <= {24'h00_0000, mask_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // addresses and trigger selection
  // ----------------------------------------------------------------
  assign ch_en = ctrl_r[`DC1_CTL_EN];
  assign start_addr = {high_r[`DC1_HI_START_MSB:`DC1_HI_START_LSB], start_r};
  assign end_addr = {high_r[`DC1_HI_END_MSB:`DC1_HI_END_LSB], end_r};
  // a word moves two neighbouring peripheral registers
  assign periph_addr = {`DC1_PERIPH_PAGE, periph_r + {7'h00, byte_idx_r}};
  assign at_end = (cur_r == end_addr);

  // source mux; the reserved code never requests
  always_comb begin
    case (ctrl_r[`DC1_CTL_SRC_MSB:`DC1_CTL_SRC_LSB])
      3'h0: trig = timer_trig[0];
      3'h1: trig = timer_trig[1];
      3'h2: trig = timer_trig[2];
      3'h3: trig = timer_trig[3];
      3'h4: trig = uart_tx_empty[0];
      3'h5: trig = uart_tx_empty[1];
      3'h6: trig = twi_tx_empty;
      default: trig = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  assign byte_done = (state_r == DC1_WRITE) & rf_ack;
  assign last_byte = at_end | ~ctrl_r[`DC1_CTL_WORD] | byte_idx_r;
  assign done_evt = byte_done & at_end;
  // one request is remembered; a further one while it waits is lost and flagged
  assign ovr_evt = ch_en & trig & pend_r & ~(state_r == DC1_IDLE);

  // pending request latch, one transfer per pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (!ch_en) begin
      pend_r <= 1'b0;
    end else if (trig) begin
      pend_r <= 1'b1;
    end else if (state_r == DC1_IDLE) begin
      pend_r <= 1'b0;
    end
  end

  // read a byte from the source, then write it to the destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DC1_IDLE;
    end else begin
      case (state_r)
        DC1_IDLE: begin
          if (ch_en && pend_r) begin
            state_r <= DC1_READ;
          end
        end
        DC1_READ: begin
          if (rf_ack) begin
            state_r <= DC1_WRITE;
          end
        end
        DC1_WRITE: begin
          if (rf_ack) begin
            // a disabled channel still finishes the byte it started
            if (last_byte || !ch_en) begin
              state_r <= DC1_IDLE;
            end else begin
              state_r <= DC1_READ;
            end
          end
        end
        default: begin
          state_r <= DC1_IDLE;
        end
      endcase
    end
  end

  // second-byte marker of a word; it also steps the peripheral address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_idx_r <= 1'b0;
    end else if (state_r == DC1_IDLE) begin
      byte_idx_r <= 1'b0;
    end else if (byte_done && !last_byte && ch_en) begin
      byte_idx_r <= 1'b1;
    end
  end

  // byte held between the read half and the write half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= 8'h00;
    end else if (state_r == DC1_READ && rf_ack) begin
      data_r <= rf_rdata;
    end
  end

  // bus drive: direction picks which side is read and which is written
  always_comb begin
    rf_req = (state_r == DC1_READ) | (state_r == DC1_WRITE);
    rf_we = (state_r == DC1_WRITE);
    rf_wdata = data_r;
    if ((state_r == DC1_READ) ^ ctrl_r[`DC1_CTL_DIR]) begin
      rf_addr = cur_r;
    end else begin
      rf_addr = periph_addr;
    end
  end

  // ----------------------------------------------------------------
  // control and address registers
  // ----------------------------------------------------------------
  // software write of enable wins over the hardware clear at end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DC1_RST_CTRL;
    end else if (wr_acc && idx == {2'h0, `DC1_IDX_CTRL}) begin
      ctrl_r <= pwdata[7:0];
    end else if (done_evt && !ctrl_r[`DC1_CTL_LOOP]) begin
      ctrl_r[`DC1_CTL_EN] <= 1'b0;
    end
  end

  // peripheral register low byte, page is fixed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_r <= `DC1_RST_BYTE;
    end else if (wr_acc && idx == {2'h0, `DC1_IDX_PADDR}) begin
      periph_r <= pwdata[7:0];
    end
  end

  // shared high nibbles of start and end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_r <= `DC1_RST_BYTE;
    end else if (wr_acc && idx == {2'h0, `DC1_IDX_HIGH}) begin
      high_r <= pwdata[7:0];
    end
  end

  // start low byte; a write while running only takes effect on reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= `DC1_RST_BYTE;
    end else if (wr_acc && idx == {2'h0, `DC1_IDX_START}) begin
      start_r <= pwdata[7:0];
    end
  end

  // end low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_r <= `DC1_RST_BYTE;
    end else if (wr_acc && idx == {2'h0, `DC1_IDX_END}) begin
      end_r <= pwdata[7:0];
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `DC1_RST_MASK;
    end else if (wr_acc && idx == {2'h0, `DC1_IDX_MASK}) begin
      mask_r <= pwdata[7:0];
    end
  end

  // current address: loaded while idle-disabled, stepped per byte, reloaded on loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= 12'h000;
    end else if (!ch_en && state_r == DC1_IDLE) begin
      cur_r <= start_addr; // channel starts from start on enable
    end else if (done_evt && ctrl_r[`DC1_CTL_LOOP]) begin
      cur_r <= start_addr;
    end else if (byte_done) begin
      cur_r <= cur_r + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and output
  // ----------------------------------------------------------------
  // reading status clears it, but an event in that same cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `DC1_RST_STAT;
    end else begin
      if (stat_rd) begin
        stat_r <= `DC1_RST_STAT;
      end
      if (done_evt && ctrl_r[`DC1_CTL_IRQEN]) begin
        stat_r[`DC1_ST_DONE] <= 1'b1;
      end
      // with interrupts off the channel flags nothing at all
      if (ovr_evt && ctrl_r[`DC1_CTL_IRQEN]) begin
        stat_r[`DC1_ST_OVR] <= 1'b1;
      end
    end
  end

  // level output while any unmasked flag stands
  assign irq = |(stat_r & mask_r);

endmodule

// *** test/dc1_channel_assertions.sv ***
// Purpose: port checks of the dma channel
// Assumes: only software changes control, apart from the hardware clear of enable at end
// Notes: bind at the foot
`timescale 1ns/100ps
`include "dc1_params.svh"
module dc1_channel_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] timer_trig,
  input wire logic [1:0] uart_tx_empty,
  input wire logic twi_tx_empty,
  input wire logic rf_req,
  input wire logic rf_we,
  input wire logic [11:0] rf_addr,
  input wire logic [7:0] rf_wdata,
  input wire logic [7:0] rf_rdata,
  input wire logic rf_ack,
  input wire logic irq
);
  logic [7:0] ctl_r;
  logic [7:0] trg;
  logic wr_ack, rd_ack, apb_acc, apb_wr;
  // ----
  // helpers
  // ----
  // software copy; hardware clear of enable unseen
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctl_r <= 8'h00;
    else if (apb_wr && paddr == {2'h0, `DC1_IDX_CTRL, 2'h0})
      ctl_r <= pwdata[7:0];
  // bit 7 stays 0 so the reserved code never matches
  assign trg = {1'h0, twi_tx_empty, uart_tx_empty, timer_trig};
  assign wr_ack = rf_req && rf_we && rf_ack;
  assign rd_ack = rf_req && !rf_we && rf_ack;
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_START: assert property (
    ctl_r[7] && trg[ctl_r[2:0]] && !rf_req && !$past(rf_req) && !$past(rf_req, 2) |-> ##2 rf_req)
    else $error("late start");
  AST_IDLE_OFF: assert property (
    (!ctl_r[7] && !rf_req) [*3] |=> !rf_req) else $error("request while off");
  AST_HOLD: assert property (
    rf_req && !rf_ack |=> rf_req && $stable(rf_addr) && $stable(rf_we)) else $error("cycle dropped");
  AST_RD_WR: assert property (
    rd_ack |=> rf_req && rf_we && rf_wdata == $past(rf_rdata)) else $error("bad write after read");
  AST_PAGE: assert property (
    rf_req && (rf_we ^ ctl_r[5]) |-> rf_addr[11:8] == `DC1_PERIPH_PAGE) else $error("off page");
  AST_ONE_BYTE: assert property (
    !ctl_r[3] && wr_ack |=> !rf_req) else $error("extra byte");
  AST_IRQ_SET: assert property (
    $rose(irq) |-> $past(wr_ack) || $past(apb_wr) || $past(rf_req && trg[ctl_r[2:0]]))
    else $error("irq without cause");
  AST_IRQ_CLR: assert property (
    $fell(irq) |-> $past(apb_acc)) else $error("irq dropped");
  cover property ($rose(irq));
  cover property (ctl_r[3] && wr_ack);
  cover property (ctl_r[5] && rd_ack);
endmodule
bind dc1_channel dc1_channel_assertions u_dc1_channel_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .timer_trig, .uart_tx_empty, .twi_tx_empty, .rf_req, .rf_we, .rf_addr,
  .rf_wdata, .rf_rdata, .rf_ack, .irq);

// *** test/dc1_rf_model.sv ***
// Purpose: register file and peripheral page
// Assumes: ack at once or three cycles late
// Notes: read data is junk outside ack
`timescale 1ns/100ps
module dc1_rf_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic rf_req,
  input wire logic rf_we,
  input wire logic [11:0] rf_addr,
  input wire logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata,
  output logic rf_ack
);
  logic [7:0] mem [4096];
  logic [1:0] wait_r = 2'h0;
  logic [7:0] junk_r = 8'hA5;
  // ----
  // bus answer
  // ----
  // stalled cycles answered once the count runs up
  assign rf_ack = rf_req && wait_r == (slow ? 2'h3 : 2'h0);
  // changing junk, so no stale byte passes
  assign rf_rdata = (rf_ack && !rf_we) ? mem[rf_addr] : junk_r;
  // wait count, junk, memory write
  always @(posedge pclk) begin
    junk_r <= junk_r + 8'h3B;
    wait_r <= (rf_req && !rf_ack) ? wait_r + 2'h1 : 2'h0;
    if (rf_req && rf_we && rf_ack)
      mem[rf_addr] <= rf_wdata;
  end
endmodule

// *** test/dc1_channel_test.sv ***
// Purpose: self-checking bench of the dma channel
// Assumes: model serves the register-file bus
// Notes: expected bus writes queued for a monitor
`timescale 1ns/100ps
`include "dc1_params.svh"
module dc1_channel_test;
  import dc1_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic slow = 1'h0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0] trg = 7'h00;
  logic [31:0] prdata;
  logic pready, pslverr, rf_req, rf_we, rf_ack, irq;
  logic [11:0] rf_addr;
  logic [7:0] rf_wdata, rf_rdata, v, p, lo;
  logic [7:0] pv [2];
  logic [8:0] q;
  logic [19:0] exp_q [$];
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 53102;
  // ----
  // clock and parts
  // ----
  always #10 pclk = ~pclk;
  dc1_channel u_dc1_channel (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_trig(trg[3:0]), .uart_tx_empty(trg[5:4]), .twi_tx_empty(trg[6]),
    .rf_req, .rf_we, .rf_addr, .rf_wdata, .rf_rdata, .rf_ack, .irq);
  dc1_rf_model u_dc1_rf_model (.pclk, .slow, .rf_req, .rf_we, .rf_addr, .rf_wdata, .rf_rdata, .rf_ack);
  // compare and verdict
  task automatic cmp(input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_reg(input logic [8:0] e, input logic [8:0] g);
    cmp({11'h0, e}, {11'h0, g});
  endtask
  task automatic chk_rf(input logic [19:0] e, input logic [19:0] g);
    cmp(e, g);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; q gets error flag and data
  task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {8'($random(seed)) & 8'h00, 16'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = {pslverr, prdata[7:0]};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] i, input logic [8:0] e);
    apb(1'h0, i, 8'h00);
    chk_reg(e, q);
  endtask
  task automatic put(input logic [11:0] a, output logic [7:0] x);
    x = 8'($random(seed));
    u_dc1_rf_model.mem[a] = x;
  endtask
  // one-cycle pulses, then wait for queued writes
  task automatic pulse(input logic [6:0] m);
    @(posedge pclk);
    trg <= m;
    @(posedge pclk);
    trg <= 7'h00;
    for (int n = 0; n < 60 && exp_q.size() != 0; n++) @(posedge pclk);
    repeat (6) @(posedge pclk);
  endtask
  // monitor: each completed write against the oldest note
  always @(posedge pclk)
    if (rf_req === 1'h1 && rf_we === 1'h1 && rf_ack === 1'h1)
      chk_rf(exp_q.size() != 0 ? exp_q.pop_front() : 20'hXXXXX, {rf_addr, rf_wdata});
  // watchdog, far beyond the expected run
  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h000, 9'h100);
    for (int i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      rd(`DC1_IDX_CTRL + 12'(i), 9'h000);
      apb(1'h1, `DC1_IDX_CTRL + 12'(i), i == 0 ? 8'h00 : v);
      rd(`DC1_IDX_CTRL + 12'(i), {1'h0, i == 0 ? 8'h00 : v});
    end
    // every source code, one byte memory to peripheral, interrupt masked
    for (int c = 0; c < 8; c++) begin
      slow <= c[0];
      v = 8'h11 * (8'($random(seed)) & 8'h07);
      p = 8'($random(seed));
      lo = 8'($random(seed));
      apb(1'h1, `DC1_IDX_HIGH, v);
      apb(1'h1, `DC1_IDX_PADDR, p);
      apb(1'h1, `DC1_IDX_START, lo);
      apb(1'h1, `DC1_IDX_END, lo);
      put({v[3:0], lo}, pv[0]);
      apb(1'h1, `DC1_IDX_CTRL, 8'h90 | 8'(c));
      pulse(~(7'h01 << c));
      if (c < 7)
        exp_q.push_back({4'hF, p, pv[0]});
      pulse(7'h01 << c);
      rd(`DC1_IDX_CTRL, {1'h0, c < 7 ? 8'h10 : 8'h90} | 9'(c));
      rd(`DC1_IDX_STAT, {8'h00, c < 7});
      chk_reg(9'h000, {8'h00, irq});
      apb(1'h1, `DC1_IDX_CTRL, 8'h10 | 8'(c));
      pulse(7'h7F);
    end
    // word mode, peripheral to memory, looping; interrupt on from the third pulse
    apb(1'h1, `DC1_IDX_MASK, 8'h01);
    p = 8'($random(seed)) & 8'hFE;
    apb(1'h1, `DC1_IDX_HIGH, 8'h33);
    apb(1'h1, `DC1_IDX_PADDR, p);
    apb(1'h1, `DC1_IDX_START, 8'h10);
    apb(1'h1, `DC1_IDX_END, 8'h13);
    put({4'hF, p}, pv[0]);
    put({4'hF, p + 8'h01}, pv[1]);
    apb(1'h1, `DC1_IDX_CTRL, 8'hE8);
    for (int k = 0; k < 5; k++) begin
      slow <= 1'($random(seed));
      if (k == 2)
        apb(1'h1, `DC1_IDX_CTRL, 8'hF8);
      for (int b = 0; b < 2; b++)
        exp_q.push_back({8'h31, 2'h0, 2'(2 * k + b), pv[b]});
      pulse(7'h01);
      rd(`DC1_IDX_START, {1'h0, 4'h1, 2'h0, 2'(2 * k + 2)});
      chk_reg({8'h00, k == 3}, {8'h00, irq});
      rd(`DC1_IDX_STAT, {8'h00, k == 3});
    end
    // three pulses two cycles apart: one runs, one waits, the third is lost
    apb(1'h1, `DC1_IDX_MASK, 8'h03);
    slow <= 1'h1;
    for (int b = 0; b < 4; b++)
      exp_q.push_back({8'h31, 2'h0, 2'(b + 2), pv[b % 2]});
    repeat (6) @(posedge pclk) trg <= {6'h00, ~trg[0]};
    pulse(7'h00);
    chk_reg(9'h001, {8'h00, irq});
    rd(`DC1_IDX_STAT, 9'h003);
    chk_reg(9'h000, 9'(exp_q.size()));
    end_of_test;
  end
endmodule
